// file: src/lqa_link_quality.sv
// Purpose: link quality data register with threshold store and sampling
// Assumes: live parameter values come from logic on mclk
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lqa_link_quality
#(
  parameter int NPARAM = 5
)
(
  input  wire logic                mclk,
  input  wire logic                sys_rst,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [NPARAM*8-1:0] paramLive,
  input  wire logic                powerDown,
  output logic                     warnIrq
);
  ////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed
  {
    logic                       wrPend;   // data phase of a write
    logic                       rdPend;   // data phase of a read
    logic [9:0]                 addr;     // latched address
    logic [15:0]                ctrl;     // control and data fields
    logic [7:0]                 sampled;  // frozen sample
    logic [NPARAM*2-1:0][7:0]   limits;   // low at 2i, high at 2i+1
    logic [NPARAM*2-1:0]        warn;     // sticky warning flags
    logic                       monEn;    // monitor enable
    logic                       irq;      // interrupt level
    logic [31:0]                rdata;    // read data
  } lqa_state_t;

  lqa_state_t st_r;   // registered state
  lqa_state_t st_nxt; // next state

  logic [NPARAM*2-1:0] hitVec;     // raw limit crossings
  logic                addrPhase;  // valid address phase
  logic [3:0]          limIdx;     // selected limit index
  logic [7:0]          selLive;    // live value of selected parameter
  logic [2:0]          selCode;    // selected parameter code
  logic [15:0]         wrVal;      // write data, low half

  ////////////////////////////////////////////////////////////////////////
  // one comparator per parameter
  genvar g;
  generate
    for (g = 0; g < NPARAM; g++)
    begin : g_cmp
      lqa_limit_cmp u_cmp
      (
        .liveVal   (paramLive[g*8 +: 8]),
        .lowLimit  (st_r.limits[2*g]),
        .highLimit (st_r.limits[2*g+1]),
        .lowHit    (hitVec[2*g]),
        .highHit   (hitVec[2*g+1])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // selection helpers
  always_comb
  begin
    addrPhase = hsel && hready && htrans[1];
    selCode   = st_r.ctrl[lqa_pkg::SEL_HI:lqa_pkg::SEL_LO];
    limIdx    = {selCode, st_r.ctrl[lqa_pkg::LIMIT_SEL_BIT]};
    selLive   = 8'h00;
    // unused selector codes 5..7 read a live value of zero
    case (selCode)
      lqa_pkg::SEL_EQ_C1:    selLive = paramLive[0  +: 8];
      lqa_pkg::SEL_GAIN:     selLive = paramLive[8  +: 8];
      lqa_pkg::SEL_BASELINE: selLive = paramLive[16 +: 8];
      lqa_pkg::SEL_FREQ_OFS: selLive = paramLive[24 +: 8];
      lqa_pkg::SEL_FREQ_CTL: selLive = paramLive[32 +: 8];
      default:               selLive = 8'h00;
    endcase
    wrVal = hwdata[15:0];
  end

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    st_nxt        = st_r;
    st_nxt.rdPend = 1'b0;
    st_nxt.wrPend = 1'b0;
    // warnings set while enabled; set beats clear-on-read below
    if (st_r.rdPend && st_r.addr == lqa_pkg::WARN_ADDR)
    begin
      st_nxt.warn = '0;
    end
    if (st_r.monEn)
    begin
      st_nxt.warn = st_nxt.warn | hitVec;
    end
    st_nxt.irq = |st_nxt.warn;
    // register write in data phase
    if (st_r.wrPend)
    begin
      case (st_r.addr)
        lqa_pkg::LQ_DATA_ADDR:
        begin
          // top bits dropped, strobe never stored
          st_nxt.ctrl = wrVal & ~lqa_pkg::RESERVED_MASK;
          st_nxt.ctrl[lqa_pkg::WSTROBE_BIT] = 1'b0;
          if (wrVal[lqa_pkg::WSTROBE_BIT] && !powerDown &&
              wrVal[lqa_pkg::SEL_HI:lqa_pkg::SEL_LO] < 3'(NPARAM))
          begin
            // new selector and data take effect together
            st_nxt.limits[{wrVal[lqa_pkg::SEL_HI:lqa_pkg::SEL_LO],
                           wrVal[lqa_pkg::LIMIT_SEL_BIT]}] = wrVal[7:0];
          end
          if (wrVal[lqa_pkg::SAMPLE_BIT])
          begin
            // fresh sequence: capture the newly selected parameter
            case (wrVal[lqa_pkg::SEL_HI:lqa_pkg::SEL_LO])
              lqa_pkg::SEL_EQ_C1:    st_nxt.sampled = paramLive[0  +: 8];
              lqa_pkg::SEL_GAIN:     st_nxt.sampled = paramLive[8  +: 8];
              lqa_pkg::SEL_BASELINE: st_nxt.sampled = paramLive[16 +: 8];
              lqa_pkg::SEL_FREQ_OFS: st_nxt.sampled = paramLive[24 +: 8];
              lqa_pkg::SEL_FREQ_CTL: st_nxt.sampled = paramLive[32 +: 8];
              default:               st_nxt.sampled = 8'h00;
            endcase
          end
        end
        lqa_pkg::MON_CTRL_ADDR:
        begin
          st_nxt.monEn = hwdata[0];
        end
        default:
        begin
          // unmapped or read-only: write ignored
        end
      endcase
    end
    // address phase latch
    if (addrPhase)
    begin
      st_nxt.addr   = haddr[9:0];
      st_nxt.wrPend = hwrite;
      st_nxt.rdPend = !hwrite;
      st_nxt.rdata  = 32'h0000_0000;
      case (haddr[9:0])
        lqa_pkg::LQ_DATA_ADDR:
        begin
          // the strobe and reserved bits are never held, so read as zero
          st_nxt.rdata[15:8] = st_r.ctrl[15:8];
          if (st_r.ctrl[lqa_pkg::SAMPLE_BIT])
          begin
            st_nxt.rdata[7:0] = st_r.sampled;
          end
          else if (selCode < 3'(NPARAM))
          begin
            st_nxt.rdata[7:0] = st_r.limits[limIdx];
          end
          else
          begin
            st_nxt.rdata[7:0] = 8'h00;
          end
        end
        lqa_pkg::PARAM_LIVE_ADDR:
        begin
          st_nxt.rdata[7:0] = selLive;
        end
        lqa_pkg::WARN_ADDR:
        begin
          st_nxt.rdata[NPARAM*2-1:0] = st_r.warn;
        end
        lqa_pkg::MON_CTRL_ADDR:
        begin
          st_nxt.rdata[0] = st_r.monEn;
        end
        default:
        begin
          st_nxt.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state register; everything clears to zero
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb
  begin
    hrdata    = st_r.rdata;
    hreadyout = 1'b1;
    hresp     = 1'b0;
    warnIrq   = st_r.irq;
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_limWrite;
    st_r.wrPend && st_r.addr == lqa_pkg::LQ_DATA_ADDR && hwdata[12] && !powerDown
      && hwdata[11:9] < 3'(NPARAM);
  endsequence

  logic [3:0] limIdxW; // index of the limit being written
  assign limIdxW = {hwdata[11:9], hwdata[8]};

  property p_limit_store;
    @(posedge mclk) disable iff (sys_rst)
    s_limWrite |=> st_r.limits[$past(limIdxW)] == $past(hwdata[7:0]);
  endproperty
  a_limit_store: assert property (p_limit_store) else $error("limit not stored");

  // the other limit of the pair must not be disturbed by a write
  property p_limit_keep;
    @(posedge mclk) disable iff (sys_rst)
    s_limWrite |=> st_r.limits[$past(limIdxW) ^ 4'h1] == $past(st_r.limits[limIdxW ^ 4'h1]);
  endproperty
  a_limit_keep: assert property (p_limit_keep) else $error("other limit moved");

  // wander high sits at index five
  property p_limit_high;
    @(posedge mclk) disable iff (sys_rst)
    s_limWrite ##0 hwdata[11:8] == 4'h5 |=> st_r.limits[5] == $past(hwdata[7:0]);
  endproperty
  a_limit_high: assert property (p_limit_high) else $error("high limit misplaced");

  property p_strobe_zero;
    @(posedge mclk) disable iff (sys_rst)
    st_r.rdPend && st_r.addr == lqa_pkg::LQ_DATA_ADDR |-> hrdata[12] == 1'b0;
  endproperty
  a_strobe_zero: assert property (p_strobe_zero) else $error("strobe read as one");

  property p_rsvd_zero;
    @(posedge mclk) disable iff (sys_rst)
    st_r.rdPend && st_r.addr == lqa_pkg::LQ_DATA_ADDR |-> hrdata[15:14] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits set");

  property p_pd_block;
    @(posedge mclk) disable iff (sys_rst)
    st_r.wrPend && powerDown && !st_r.rdPend |=> st_r.limits == $past(st_r.limits);
  endproperty
  a_pd_block: assert property (p_pd_block) else $error("limit written while down");

  property p_sample_freeze;
    @(posedge mclk) disable iff (sys_rst)
    !(st_r.wrPend && hwdata[13]) |=> st_r.sampled == $past(st_r.sampled);
  endproperty
  a_sample_freeze: assert property (p_sample_freeze) else $error("sample moved");

  property p_sample_take;
    @(posedge mclk) disable iff (sys_rst)
    st_r.wrPend && st_r.addr == lqa_pkg::LQ_DATA_ADDR && hwdata[13]
      && hwdata[11:9] == 3'h0 |=> st_r.sampled == $past(paramLive[7:0]);
  endproperty
  a_sample_take: assert property (p_sample_take) else $error("sample not taken");

  // the last selector code reaches the last live byte
  property p_sample_ctl;
    @(posedge mclk) disable iff (sys_rst)
    st_r.wrPend && st_r.addr == lqa_pkg::LQ_DATA_ADDR && hwdata[13]
      && hwdata[11:9] == 3'h4 |=> st_r.sampled == $past(paramLive[39:32]);
  endproperty
  a_sample_ctl: assert property (p_sample_ctl) else $error("control not sampled");

  // the live read follows the same selector as sampling
  property p_live_sel;
    @(posedge mclk) disable iff (sys_rst)
    addrPhase && !hwrite && haddr[9:0] == lqa_pkg::PARAM_LIVE_ADDR
      && st_r.ctrl[11:9] == 3'h2 |=> hrdata[7:0] == $past(paramLive[23:16]);
  endproperty
  a_live_sel: assert property (p_live_sel) else $error("live value wrong");

  property p_read_sample;
    @(posedge mclk) disable iff (sys_rst)
    addrPhase && !hwrite && haddr[9:0] == lqa_pkg::LQ_DATA_ADDR && st_r.ctrl[13]
      |=> hrdata[7:0] == $past(st_r.sampled);
  endproperty
  a_read_sample: assert property (p_read_sample) else $error("sample not read");

  property p_read_limit;
    @(posedge mclk) disable iff (sys_rst)
    addrPhase && !hwrite && haddr[9:0] == lqa_pkg::LQ_DATA_ADDR && !st_r.ctrl[13]
      && st_r.ctrl[11:9] == 3'h1 && st_r.ctrl[8] |=> hrdata[7:0] == $past(st_r.limits[3]);
  endproperty
  a_read_limit: assert property (p_read_limit) else $error("limit read wrong");

  property p_warn_irq;
    @(posedge mclk) disable iff (sys_rst)
    st_r.monEn && |hitVec |=> st_r.warn != '0 ##0 warnIrq;
  endproperty
  a_warn_irq: assert property (p_warn_irq) else $error("warning not raised");

  // limits parked at the far ends can never report a crossing
  property p_end_off;
    @(posedge mclk) disable iff (sys_rst)
    st_r.limits[0] == lqa_pkg::LIMIT_MAX && st_r.limits[1] == lqa_pkg::LIMIT_MIN
      |-> hitVec[1:0] == 2'b00;
  endproperty
  a_end_off: assert property (p_end_off) else $error("parked limit fired");

  property p_reset_zero;
    @(posedge mclk)
    sys_rst |=> st_r.ctrl == lqa_pkg::LQ_DATA_RESET && !warnIrq;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("reset not zero");
endmodule
`default_nettype wire

// file: src/lqa_pkg.sv
// Purpose: shared constants for the link quality threshold access block
// Assumes: 32-bit AHB-Lite register bus, one 16-bit register in the low half
// Notes: offsets are byte addresses; the register index is kept too
`default_nettype none
package lqa_pkg;
  // register index and its byte address, four times the index
  localparam logic [7:0]  LQ_DATA_INDEX    = 8'h1e;
  localparam logic [9:0]  LQ_DATA_ADDR     = {LQ_DATA_INDEX, 2'b00};
  // extra registers of this block
  localparam logic [9:0]  PARAM_LIVE_ADDR  = 10'h100;  // live parameter inputs, read only
  localparam logic [9:0]  WARN_ADDR        = 10'h104;  // warning flags, clear on read
  localparam logic [9:0]  MON_CTRL_ADDR    = 10'h108;  // bit0 monitor enable
  // field positions
  localparam int          SAMPLE_BIT       = 13;
  localparam int          WSTROBE_BIT      = 12;
  localparam int          SEL_HI           = 11;
  localparam int          SEL_LO           = 9;
  localparam int          LIMIT_SEL_BIT    = 8;
  // counts and reset values
  localparam int          NUM_PARAMS       = 5;
  localparam int          NUM_LIMITS       = 10;
  localparam logic [15:0] LQ_DATA_RESET    = 16'h0000;
  localparam logic [7:0]  LIMIT_RESET      = 8'h00;
  localparam logic [7:0]  LIMIT_MAX        = 8'hff;
  localparam logic [7:0]  LIMIT_MIN        = 8'h00;
  localparam logic [15:0] RESERVED_MASK    = 16'hc000;
  // parameter selector codes
  typedef enum logic [2:0]
  {
    SEL_EQ_C1    = 3'h0,
    SEL_GAIN     = 3'h1,
    SEL_BASELINE = 3'h2,
    SEL_FREQ_OFS = 3'h3,
    SEL_FREQ_CTL = 3'h4
  } lqa_param_t;
endpackage
`default_nettype wire

// file: src/lqa_limit_cmp.sv
// Purpose: compare one live parameter with its low and high limits
// Assumes: signed-free 8-bit compare, limits at min or max are disabled
// Notes: purely combinational; instantiated once per parameter
`timescale 1ns/100ps
`default_nettype none
module lqa_limit_cmp
(
  input  wire logic [7:0] liveVal,
  input  wire logic [7:0] lowLimit,
  input  wire logic [7:0] highLimit,
  output logic            lowHit,
  output logic            highHit
);
  // a limit parked at either end of the range is off, whichever side it guards;
  // otherwise a low limit at max or a high limit at min would fire on nearly every value
  always_comb
  begin
    lowHit  = (lowLimit != lqa_pkg::LIMIT_MIN) && (lowLimit != lqa_pkg::LIMIT_MAX)
              && (liveVal < lowLimit);
    highHit = (highLimit != lqa_pkg::LIMIT_MIN) && (highLimit != lqa_pkg::LIMIT_MAX)
              && (liveVal > highLimit);
  end
endmodule
`default_nettype wire

// file: verif/tb_lqa_link_quality.sv
// Purpose: self-checking bench for the link quality data register block
// Assumes: one AHB-Lite slave, its hreadyout fed back as hready
// Notes: expectations come from a shadow model of limits and sampling
`timescale 1ns/100ps
`default_nettype none
module tb_lqa_link_quality;
  localparam int TMO = 5000;  // cycle ceiling, well above the run
  logic        mclk         = 1'b0;
  logic        sys_rst      = 1'b1;
  logic        hsel         = 1'b0;
  logic [31:0] haddr        = 32'h0000_0000;
  logic [1:0]  htrans       = 2'b00;
  logic        hwrite       = 1'b0;
  logic [2:0]  hsize        = 3'b010;  // whole words only
  logic [31:0] hwdata       = 32'h0000_0000;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [39:0] paramLive    = 40'h00_0000_0000;
  logic        powerDown    = 1'b0;
  logic        warnIrq;
  int          n_fail       = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  logic [7:0]  lim [10];   // shadow limit store
  logic        smp;        // shadow sample bit
  logic        lsel;       // shadow low/high select
  logic [2:0]  sel;        // shadow parameter selector
  logic [7:0]  cap;        // shadow captured value
  logic [31:0] rd;
  logic [15:0] w;

  lqa_link_quality #(.NPARAM(lqa_pkg::NUM_PARAMS)) lqa_link_quality_inst
  (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hwdata    (hwdata),
    .hready    (hreadyout),
    .hrdata    (hrdata),
    .hreadyout (hreadyout),
    .hresp     (hresp),
    .paramLive (paramLive),
    .powerDown (powerDown),
    .warnIrq   (warnIrq)
  );

  ////////////////////////////////////////////////////////////////////
  // clock and hang guard
  always #2.5 mclk = ~mclk;

  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == TMO)
    begin
      n_fail++;
      $display("Error at %0t: timeout", $time);
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // verdict, the single end of the run
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge
  task automatic xfer(input logic [9:0] a, input logic wr, input logic [31:0] wd,
                      output logic [31:0] r);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {22'h0, a};
    hwrite <= wr;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge mclk);
    while (hreadyout !== 1'b1) @(posedge mclk);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
    // idle gap: read data is latched early, so a readback needs it
    @(posedge mclk);
  endtask

  ////////////////////////////////////////////////////////////////////
  // shadow model of the data register
  function automatic logic [31:0] expLq();
    // selector codes past the last parameter hold no limit and read zero
    return {16'h0, 2'b00, smp, 1'b0, sel, lsel,
            smp ? cap : (sel < 3'h5 ? lim[{sel, lsel}] : 8'h00)};
  endfunction

  task automatic wr16(input logic [15:0] v);
    xfer(lqa_pkg::LQ_DATA_ADDR, 1'b1, {16'h0, v}, rd);
    smp  = v[13];
    sel  = v[11:9];
    lsel = v[8];
    if (v[13])
      cap = (v[11:9] < 3'h5) ? paramLive[v[11:9]*8 +: 8] : 8'h00;
    // powered down or out-of-range selector leaves limits alone
    if (v[12] && powerDown !== 1'b1 && v[11:9] < 3'h5)
      lim[{v[11:9], v[8]}] = v[7:0];
  endtask

  task automatic lqCheck();
    xfer(lqa_pkg::LQ_DATA_ADDR, 1'b0, 32'h0, rd);
    chk(rd, expLq());
  endtask

  // write all ten limits (random or lo/hi), then read each back
  task automatic setLimits(input logic rnd, input logic [7:0] lo, input logic [7:0] hi);
    logic [7:0] v;
    for (int i = 0; i < 10; i++)
    begin
      v = rnd ? 8'($urandom) : (i[0] ? hi : lo);
      wr16({2'b11, 1'b0, 1'b1, 3'(i / 2), i[0], v});
      lqCheck();
    end
    for (int i = 0; i < 10; i++)
    begin
      wr16({4'b0000, 3'(i / 2), i[0], 8'h5a});
      lqCheck();
    end
  endtask

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    void'($urandom(9400));
    for (int i = 0; i < 10; i++)
      lim[i] = 8'h00;
    smp  = 1'b0;
    lsel = 1'b0;
    sel  = 3'h0;
    cap  = 8'h00;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    lqCheck();
    chk({31'h0, warnIrq}, 32'h0);
    setLimits(1'b1, 8'h00, 8'h00);
    // sample each parameter, then move the live value
    for (int p = 0; p < 5; p++)
    begin
      paramLive <= {8'($urandom), 32'($urandom)};
      @(posedge mclk);
      wr16({4'b0010, 3'(p), 1'b0, 8'h00});
      lqCheck();
      paramLive <= ~paramLive;
      @(posedge mclk);
      lqCheck();
      xfer(lqa_pkg::PARAM_LIVE_ADDR, 1'b0, 32'h0, rd);
      chk(rd, {24'h0, paramLive[p*8 +: 8]});
    end
    // threshold write while powered down
    powerDown <= 1'b1;
    @(posedge mclk);
    wr16({4'b0001, 3'h3, 1'b1, ~lim[7]});
    wr16(16'h0700);
    lqCheck();
    powerDown <= 1'b0;
    // unmapped place reads zero, write has no effect
    xfer(10'h200, 1'b1, 32'hffff_ffff, rd);
    xfer(10'h200, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    lqCheck();
    // low parked at max, high at min: would fire on most values unless off
    setLimits(1'b0, lqa_pkg::LIMIT_MAX, lqa_pkg::LIMIT_MIN);
    paramLive <= {8'($urandom), 32'($urandom)};
    xfer(lqa_pkg::MON_CTRL_ADDR, 1'b1, 32'h1, rd);
    repeat (4) @(posedge mclk);
    xfer(lqa_pkg::WARN_ADDR, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    chk({31'h0, warnIrq}, 32'h0);
    paramLive[15:8] <= 8'h10;
    wr16({4'b0001, 3'h1, 1'b0, 8'h40});
    for (int k = 0; k < 8 && warnIrq !== 1'b1; k++) @(posedge mclk);
    chk({31'h0, warnIrq}, 32'h1);
    paramLive[15:8] <= 8'h80;
    xfer(lqa_pkg::WARN_ADDR, 1'b0, 32'h0, rd);
    chk(rd, 32'h4);
    xfer(lqa_pkg::WARN_ADDR, 1'b0, 32'h0, rd);
    chk(rd, 32'h0);
    for (int k = 0; k < 8 && warnIrq !== 1'b0; k++) @(posedge mclk);
    chk({31'h0, warnIrq}, 32'h0);
    // random mix of sampling, strobes and power-down
    for (int n = 0; n < 60; n++)
    begin
      w = 16'($urandom);
      w[11:9] = 3'($urandom_range(7));  // codes 5..7 must refuse writes
      powerDown <= ($urandom_range(3) == 0);
      if (n % 4 == 0)
        paramLive <= {8'($urandom), 32'($urandom)};
      @(posedge mclk);
      wr16(w);
      lqCheck();
    end
    // reset in mid-run: fields, limits and flags all back to zero
    sys_rst <= 1'b1;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 10; i++)
      lim[i] = 8'h00;
    {smp, sel, lsel, cap} = '0;
    lqCheck();
    chk({31'h0, warnIrq}, 32'h0);
    wr16(16'h0900);
    lqCheck();
    summarize();
  end
endmodule
`default_nettype wire
